// ### eac_device.sv
// eeprom block: io registers, self-timed write, stalled read, ready irq
// assumes the cpu issues no io access while stall is high
`timescale 1ns/1ps
`default_nettype none
module eac_device #(
	parameter int unsigned RC_DIV      = eac_pkg::RC_DIV,
	parameter int unsigned WRITE_TICKS = eac_pkg::WRITE_TICKS
) (
	input  wire logic CORE_CLK,
	input  wire logic SYS_RST,
	eac_if.dev        BUS,
	output logic      WRITE_ACTIVE,
	output logic      WRITE_ABORT
);
	logic [7:0]  mem [eac_pkg::DEPTH];
	logic [6:0]  loc;
	logic [7:0]  data;
	logic        rie;
	logic        mwe;
	logic [1:0]  mwe_cnt;
	logic        we;
	logic        re;
	logic [2:0]  stall_cnt;
	logic        wr_loc;
	logic        wr_data;
	logic        wr_ctl;
	logic        start_wr;
	logic        start_rd;
	logic        disturb;
	logic        t_busy;
	logic        t_done;
	logic [7:0]  next_rdata;

	// ----------------------------------------
	// io write decode
	// ----------------------------------------
	assign wr_loc  = BUS.io_wr && (BUS.io_addr == eac_pkg::IO_ADDR);
	assign wr_data = BUS.io_wr && (BUS.io_addr == eac_pkg::IO_DATA);
	assign wr_ctl  = BUS.io_wr && (BUS.io_addr == eac_pkg::IO_CTRL);
	assign start_wr = wr_ctl && BUS.io_wdata[eac_pkg::CTL_WE] && mwe && !we;
	assign start_rd = wr_ctl && BUS.io_wdata[eac_pkg::CTL_RE] && !start_wr;
	assign disturb  = we && (wr_loc || wr_data || start_rd);

	// ----------------------------------------
	// write timer
	// ----------------------------------------
	// power-on reset only, so a cpu reset leaves a running write alone
	eac_wtimer #(
		.DIV   (RC_DIV),
		.TICKS (WRITE_TICKS)
	) i_eac_wtimer (
		.clk   (CORE_CLK),
		.rst   (SYS_RST),
		.start (start_wr),
		.abort (disturb),
		.busy  (t_busy),
		.done  (t_done)
	);

	// ----------------------------------------
	// address and data registers
	// ----------------------------------------
	// seven-bit location
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			loc <= 7'h00;
		end else if (wr_loc) begin
			loc <= BUS.io_wdata[eac_pkg::LOC_W-1:0];
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			data <= 8'h00;
		end else if (wr_data) begin
			data <= BUS.io_wdata;
		end else if (start_rd) begin
			data <= mem[loc];
		end
	end

	// array update at end of write
	always_ff @(posedge CORE_CLK) begin
		if (t_done) begin
			mem[loc] <= data;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// rie and mwe clear on any reset; we is left to its own block
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rie <= 1'b0;
		end else if (BUS.cpu_rst) begin
			rie <= 1'b0;
		end else if (wr_ctl) begin
			rie <= BUS.io_wdata[eac_pkg::CTL_RIE];
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mwe     <= 1'b0;
			mwe_cnt <= 2'h0;
		end else if (BUS.cpu_rst) begin
			mwe     <= 1'b0;
			mwe_cnt <= 2'h0;
		end else if (wr_ctl && BUS.io_wdata[eac_pkg::CTL_MWE] && !mwe) begin
			mwe     <= 1'b1;
			mwe_cnt <= eac_pkg::MWE_HOLD;
		end else if (mwe) begin
			if (mwe_cnt == 2'h0) begin
				mwe <= 1'b0;
			end else begin
				mwe_cnt <= mwe_cnt - 2'h1;
			end
		end
	end

	// cpu reset does not touch it
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			we <= 1'b0;
		end else if (start_wr) begin
			we <= 1'b1;
		end else if (t_done || disturb || !t_busy) begin
			we <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stall_cnt <= 3'h0;
			re        <= 1'b0;
		end else if (BUS.cpu_rst) begin
			stall_cnt <= 3'h0;
			re        <= 1'b0;
		end else if (start_wr) begin
			stall_cnt <= eac_pkg::STALL_WR;
		end else if (start_rd) begin
			stall_cnt <= eac_pkg::STALL_RD;
			re        <= 1'b1;
		end else if (stall_cnt != 3'h0) begin
			stall_cnt <= stall_cnt - 3'h1;
			if (stall_cnt == 3'h1) begin
				re <= 1'b0;
			end
		end
	end

	assign BUS.stall = (stall_cnt != 3'h0);

	// ----------------------------------------
	// ready interrupt
	// ----------------------------------------
	// level while write idle
	assign BUS.irq_req = rie && BUS.gie && !we;

	// ----------------------------------------
	// power-down during write
	// ----------------------------------------
	// write runs on; clock stays up after it finishes in sleep
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BUS.osc_hold <= 1'b0;
		end else if (!BUS.sleep_pd) begin
			BUS.osc_hold <= 1'b0;
		end else if (t_done || we) begin
			BUS.osc_hold <= 1'b1;
		end
	end

	// ----------------------------------------
	// io read path
	// ----------------------------------------
	// top address bit zero
	always_comb begin
		next_rdata = 8'h00;
		if (BUS.io_addr == eac_pkg::IO_ADDR) begin
			next_rdata = {1'b0, loc};
		end else if (BUS.io_addr == eac_pkg::IO_DATA) begin
			next_rdata = data;
		end else if (BUS.io_addr == eac_pkg::IO_CTRL) begin
			next_rdata = {eac_pkg::CTL_RSVD, rie, mwe, we, re};
		end
	end

	// read data is sampled one cycle after the address is shown
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BUS.io_rdata <= 8'h00;
		end else begin
			BUS.io_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// user-side status
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			WRITE_ACTIVE <= 1'b0;
			WRITE_ABORT  <= 1'b0;
		end else begin
			WRITE_ACTIVE <= we;
			WRITE_ABORT  <= disturb;
		end
	end
endmodule
`default_nettype wire

// ### eac_host.sv
// core-side sequencer: apb registers in, eeprom io sequences out
// assumes the device answers io reads one cycle after the address
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module eac_host (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             IRQ,
	eac_if.cpu               BUS
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000, S_POLL = 4'b0001, S_PCHK = 4'b0010, S_WADR = 4'b0011,
		S_WDAT = 4'b0100, S_WMWE = 4'b0101, S_WWE  = 4'b0110, S_RADR = 4'b0111,
		S_RRE  = 4'b1000, S_RGET = 4'b1001, S_RCAP = 4'b1010, S_END  = 4'b1011
	} eac_state_t;
	eac_state_t state;
	eac_state_t next_state;
	logic [1:0] ctrl;
	logic       rw;
	logic [6:0] loc;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [1:0] istat;
	logic [1:0] imask;
	logic       irq_d;
	logic       wr_acc;
	logic       known;
	logic [1:0] ev;

	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign known  = (PADDR <= eac_pkg::H_IMASK) && (PADDR[1:0] == 2'b00);
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !known;
	assign ev = {BUS.irq_req && !irq_d, state == S_END && !BUS.stall};

	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ctrl  <= 2'h0;
			loc   <= 7'h00;
			wdata <= 8'h00;
			imask <= 2'h0;
			BUS.cpu_rst <= 1'b0;
		end else begin
			BUS.cpu_rst <= wr_acc && PADDR == eac_pkg::H_CTRL && PWDATA[eac_pkg::HC_RST];
			if (wr_acc && PADDR == eac_pkg::H_CTRL) begin
				ctrl <= PWDATA[1:0];
			end else if (wr_acc && PADDR == eac_pkg::H_ADDR) begin
				loc <= PWDATA[6:0];
			end else if (wr_acc && PADDR == eac_pkg::H_WDATA) begin
				wdata <= PWDATA[7:0];
			end else if (wr_acc && PADDR == eac_pkg::H_IMASK) begin
				imask <= PWDATA[1:0];
			end
		end
	end

	// events win over a same-cycle write-one clear
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			istat <= eac_pkg::EV_NONE;
			irq_d <= 1'b0;
		end else begin
			irq_d <= BUS.irq_req;
			if (wr_acc && PADDR == eac_pkg::H_ISTAT) begin
				istat <= (istat & ~PWDATA[1:0]) | ev;
			end else begin
				istat <= istat | ev;
			end
		end
	end

	assign IRQ = |(istat & imask);
	assign BUS.gie      = ctrl[eac_pkg::HC_GIE];
	assign BUS.sleep_pd = ctrl[eac_pkg::HC_SLEEP];

	always_comb begin
		PRDATA = 32'h0000_0000;
		if (PADDR == eac_pkg::H_CTRL) begin
			PRDATA = {30'h0, ctrl};
		end else if (PADDR == eac_pkg::H_ADDR) begin
			PRDATA = {25'h0, loc};
		end else if (PADDR == eac_pkg::H_WDATA) begin
			PRDATA = {24'h0, wdata};
		end else if (PADDR == eac_pkg::H_RDATA) begin
			PRDATA = {24'h0, rdata};
		end else if (PADDR == eac_pkg::H_STAT) begin
			PRDATA = {29'h0, BUS.osc_hold, BUS.irq_req, state != S_IDLE};
		end else if (PADDR == eac_pkg::H_ISTAT) begin
			PRDATA = {30'h0, istat};
		end else if (PADDR == eac_pkg::H_IMASK) begin
			PRDATA = {30'h0, imask};
		end
	end

	// ----------------------------------------
	// io sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= S_IDLE;
			rw    <= 1'b0;
		end else begin
			state <= next_state;
			if (state == S_IDLE) begin
				rw <= PWDATA[eac_pkg::CMD_WR];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata <= 8'h00;
		end else if (state == S_RCAP) begin
			rdata <= BUS.io_rdata;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (wr_acc && PADDR == eac_pkg::H_CMD && PWDATA[eac_pkg::CMD_GO]) begin
					next_state = S_POLL;
				end
			end
			S_PCHK: begin
				if (BUS.io_rdata[eac_pkg::CTL_WE]) begin
					next_state = S_POLL;
				end else begin
					next_state = rw ? S_WADR : S_RADR;
				end
			end
			S_RCAP: next_state = S_END;
			S_END: begin
				if (!BUS.stall) begin
					next_state = S_IDLE;
				end
			end
			default: begin
				if (!BUS.stall) begin
					case (state)
						S_POLL:  next_state = S_PCHK;
						S_WADR:  next_state = S_WDAT;
						S_WDAT:  next_state = S_WMWE;
						S_WMWE:  next_state = S_WWE;
						S_WWE:   next_state = S_END;
						S_RADR:  next_state = S_RRE;
						S_RRE:   next_state = S_RGET;
						S_RGET:  next_state = S_RCAP;
						default: next_state = S_IDLE;
					endcase
				end
			end
		endcase
	end

	// control writes keep rie clear, so the ready irq stays off whatever the gie bit
	always_comb begin
		BUS.io_addr  = eac_pkg::IO_CTRL;
		BUS.io_wr    = 1'b0;
		BUS.io_rd    = 1'b0;
		BUS.io_wdata = 8'h00;
		if (!BUS.stall) begin
			case (state)
				S_POLL: BUS.io_rd = 1'b1;
				S_WADR, S_RADR: begin
					BUS.io_addr  = eac_pkg::IO_ADDR;
					BUS.io_wr    = 1'b1;
					BUS.io_wdata = {1'b0, loc};
				end
				S_WDAT: begin
					BUS.io_addr  = eac_pkg::IO_DATA;
					BUS.io_wr    = 1'b1;
					BUS.io_wdata = wdata;
				end
				S_WMWE: begin
					BUS.io_wr    = 1'b1;
					BUS.io_wdata = 8'h04;
				end
				S_WWE: begin
					BUS.io_wr    = 1'b1;
					BUS.io_wdata = 8'h06;
				end
				S_RRE: begin
					BUS.io_wr    = 1'b1;
					BUS.io_wdata = 8'h01;
				end
				S_RGET: begin
					BUS.io_addr = eac_pkg::IO_DATA;
					BUS.io_rd   = 1'b1;
				end
				default: BUS.io_rd = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### eac_if.sv
// cpu io bus between the core side and the eeprom block
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface eac_if;
	logic [5:0] io_addr;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       stall;
	logic       irq_req;
	logic       gie;
	logic       sleep_pd;
	logic       osc_hold;
	logic       cpu_rst;
	modport dev (input io_addr, io_wr, io_rd, io_wdata, gie, sleep_pd, cpu_rst,
		output io_rdata, stall, irq_req, osc_hold);
	modport cpu (output io_addr, io_wr, io_rd, io_wdata, gie, sleep_pd, cpu_rst,
		input io_rdata, stall, irq_req, osc_hold);
endinterface
`default_nettype wire

// ### eac_pkg.sv
// constants shared by both ends of the eeprom access link
// assumes one 50 MHz core clock for both ends
package eac_pkg;
	// ----------------------------------------
	// io register map of the eeprom block
	// ----------------------------------------
	localparam logic [5:0] IO_ADDR = 6'h1f;
	localparam logic [5:0] IO_DATA = 6'h1d;
	localparam logic [5:0] IO_CTRL = 6'h1c;
	localparam int CTL_RIE = 3;
	localparam int CTL_MWE = 2;
	localparam int CTL_WE  = 1;
	localparam int CTL_RE  = 0;
	localparam int LOC_W   = 7;
	localparam int DEPTH   = 128;
	localparam logic [3:0] CTL_RSVD = 4'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CORE_HZ     = 50_000_000;
	localparam int unsigned RC_HZ       = 1_000_000;
	localparam int unsigned RC_DIV      = CORE_HZ / RC_HZ;
	localparam int unsigned WRITE_TICKS = 8448;
	localparam logic [1:0] MWE_HOLD   = 2'h3;
	localparam logic [2:0] STALL_WR   = 3'h2;
	localparam logic [2:0] STALL_RD   = 3'h4;
	// ----------------------------------------
	// host apb register map
	// ----------------------------------------
	localparam logic [7:0] H_CTRL  = 8'h00;
	localparam logic [7:0] H_CMD   = 8'h04;
	localparam logic [7:0] H_ADDR  = 8'h08;
	localparam logic [7:0] H_WDATA = 8'h0c;
	localparam logic [7:0] H_RDATA = 8'h10;
	localparam logic [7:0] H_STAT  = 8'h14;
	localparam logic [7:0] H_ISTAT = 8'h18;
	localparam logic [7:0] H_IMASK = 8'h1c;
	localparam int HC_GIE   = 0;
	localparam int HC_SLEEP = 1;
	localparam int HC_RST   = 2;
	localparam int CMD_GO   = 0;
	localparam int CMD_WR   = 1;
	localparam int EV_DONE  = 0;
	localparam int EV_READY = 1;
	localparam logic [1:0] EV_NONE = 2'h0;
endpackage

// ### eac_props.sv
// checker for the cpu io link between the host sequencer and the eeprom block
// assumes one core clock; link signals are wired in by name beside the interface
`timescale 1ns/1ps
`default_nettype none
module eac_props #(
	parameter int unsigned RC_DIV      = eac_pkg::RC_DIV,
	parameter int unsigned WRITE_TICKS = eac_pkg::WRITE_TICKS
) (
	input wire logic       CORE_CLK,
	input wire logic       SYS_RST,
	input wire logic [5:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       stall,
	input wire logic       irq_req,
	input wire logic       gie,
	input wire logic       sleep_pd,
	input wire logic       osc_hold,
	input wire logic       cpu_rst
);
	// margins absorb the unknown phase of the slow write tick
	localparam int BUSY_MIN = (WRITE_TICKS - 1) * RC_DIV;
	localparam int BUSY_MAX = (WRITE_TICKS + 1) * RC_DIV + 2;
	logic        ctl_wr;
	logic        wr_go;
	logic        rd_go;
	logic        armed;
	logic [19:0] age;
	assign ctl_wr = io_wr && io_addr == eac_pkg::IO_CTRL;
	assign wr_go  = ctl_wr && armed && io_wdata[2:0] == 3'h6;
	assign rd_go  = ctl_wr && io_wdata[eac_pkg::CTL_RE];
	// ----------------------------------------
	// cycles since the last write start
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			armed <= 1'b0;
			age   <= 20'h00000;
		end else begin
			armed <= ctl_wr && io_wdata[2:0] == 3'h4;
			if (wr_go)
				age <= 20'h00001;
			else if (age != 20'h00000 && age != 20'hfffff)
				age <= age + 20'h00001;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	a_ctrl_rsvd_zero: assert property (
		io_addr == eac_pkg::IO_CTRL |=> io_rdata[7:4] == 4'h0)
		else $error("control reserved bits not zero");
	a_addr_top_zero: assert property (
		io_addr == eac_pkg::IO_ADDR |=> !io_rdata[7])
		else $error("address top bit not zero");
	a_write_stall_two: assert property (
		wr_go |=> stall [*2] ##1 !stall)
		else $error("write stall not two cycles");
	a_read_stall_four: assert property (
		rd_go |=> stall [*4] ##1 !stall)
		else $error("read stall not four cycles");
	a_quiet_in_stall: assert property (
		stall |-> !io_wr)
		else $error("io write during stall");
	a_gie_gates_irq: assert property (
		!gie |-> !irq_req)
		else $error("ready irq without global enable");
	a_irq_busy_low: assert property (
		wr_go |=> !irq_req [*4])
		else $error("ready irq during write");
	a_we_held_busy: assert property (
		io_addr == eac_pkg::IO_CTRL && age >= 1 && age <= BUSY_MIN
		|=> io_rdata[eac_pkg::CTL_WE])
		else $error("write bit dropped early");
	a_we_clear_done: assert property (
		io_addr == eac_pkg::IO_CTRL && !io_wr && age > BUSY_MAX
		|=> !io_rdata[eac_pkg::CTL_WE])
		else $error("write bit stuck");
	a_osc_kept_sleep: assert property (
		sleep_pd && age >= 1 && age <= BUSY_MIN |-> ##[0:2] osc_hold)
		else $error("oscillator not held in sleep");
	a_rst_ends_stall: assert property (
		cpu_rst |=> !stall)
		else $error("stall survives reset pulse");
	c_write_go: cover property (wr_go);
	c_read_go: cover property (rd_go);
	c_rst_in_write: cover property (cpu_rst && age >= 1 && age <= BUSY_MIN);
	c_sleep_write: cover property (sleep_pd && age == 20'h00002);
endmodule
`default_nettype wire

// ### eac_wtimer.sv
// self-timed write timer on a 1 MHz tick derived from the core clock
// assumes only the power-on reset or an abort stops it
`timescale 1ns/1ps
`default_nettype none
module eac_wtimer #(
	parameter int unsigned DIV   = eac_pkg::RC_DIV,
	parameter int unsigned TICKS = eac_pkg::WRITE_TICKS
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic abort,
	output logic      busy,
	output logic      done
);
	logic [15:0] pre;
	logic [15:0] ticks;
	// ----------------------------------------
	// prescaler and tick count
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre   <= 16'h0000;
			ticks <= 16'h0000;
			busy  <= 1'b0;
		end else begin
			if (start) begin
				busy  <= 1'b1;
				pre   <= 16'h0000;
				ticks <= 16'h0000;
			end else if (abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (pre == 16'(DIV - 1)) begin
					pre <= 16'h0000;
					if (ticks == 16'(TICKS - 1)) begin
						busy <= 1'b0;
					end else begin
						ticks <= ticks + 16'h0001;
					end
				end else begin
					pre <= pre + 16'h0001;
				end
			end
		end
	end

	// done rides the last tick, so the write bit falls on the final rc edge, not one later
	assign done = busy && !start && !abort && pre == 16'(DIV - 1) && ticks == 16'(TICKS - 1);
endmodule
`default_nettype wire

// ### eeprom_access_controller_bench.sv
// bench: apb on the host joined to one device, a second device driven raw
// assumes write timing shortened through RC_DIV and WRITE_TICKS
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_controller_bench;
	localparam int unsigned DIV = 2;
	localparam int unsigned TCK = 8;
	logic        core_clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        last_err;
	logic        wr_act;
	logic        wr_abt;
	logic        wr_act2;
	logic        wr_abt2;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	eac_if i_eac_if ();
	eac_if i_eac_if_2 ();
	eac_host i_eac_host (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .BUS(i_eac_if.cpu));
	eac_device #(.RC_DIV(DIV), .WRITE_TICKS(TCK)) i_eac_device (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .BUS(i_eac_if.dev), .WRITE_ACTIVE(wr_act), .WRITE_ABORT(wr_abt));
	eac_device #(.RC_DIV(DIV), .WRITE_TICKS(TCK)) i_eac_device_2 (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .BUS(i_eac_if_2.dev), .WRITE_ACTIVE(wr_act2),
		.WRITE_ABORT(wr_abt2));
	eac_props #(.RC_DIV(DIV), .WRITE_TICKS(TCK)) i_eac_props (.CORE_CLK(core_clk),
		.SYS_RST(sys_rst), .io_addr(i_eac_if.io_addr), .io_wr(i_eac_if.io_wr),
		.io_rd(i_eac_if.io_rd), .io_wdata(i_eac_if.io_wdata), .io_rdata(i_eac_if.io_rdata),
		.stall(i_eac_if.stall), .irq_req(i_eac_if.irq_req), .gie(i_eac_if.gie),
		.sleep_pd(i_eac_if.sleep_pd), .osc_hold(i_eac_if.osc_hold), .cpu_rst(i_eac_if.cpu_rst));
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q);
	endtask
	// polls the host busy flag; a hang here counts as a mismatch
	task automatic idle();
		logic [31:0] q;
		q = 32'h1;
		for (int i = 0; i < 100 && q[0] !== 1'b0; i++)
			rd(eac_pkg::H_STAT, q);
		chk("host busy", 32'h0, {31'h0, q[0]});
	endtask
	task automatic ee_write(input logic [6:0] loc, input logic [7:0] d);
		wr(eac_pkg::H_ADDR, {25'h0, loc});
		wr(eac_pkg::H_WDATA, {24'h0, d});
		wr(eac_pkg::H_CMD, 32'h3);
		idle();
	endtask
	task automatic ee_check(input logic [6:0] loc, input logic [7:0] d);
		logic [31:0] q;
		wr(eac_pkg::H_ADDR, {25'h0, loc});
		wr(eac_pkg::H_CMD, 32'h1);
		idle();
		rd(eac_pkg::H_RDATA, q);
		chk("read byte", {24'h0, d}, q);
	endtask
	task automatic io_w(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		i_eac_if_2.io_addr  <= a;
		i_eac_if_2.io_wdata <= d;
		i_eac_if_2.io_wr    <= 1'b1;
		@(posedge core_clk);
		i_eac_if_2.io_wr <= 1'b0;
	endtask
	task automatic io_r(input logic [5:0] a, output logic [7:0] q);
		@(posedge core_clk);
		i_eac_if_2.io_addr <= a;
		repeat (2) @(posedge core_clk);
		q = i_eac_if_2.io_rdata;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		rd(eac_pkg::H_CTRL, q);
		chk("host ctrl", 32'h0, q);
		rd(eac_pkg::H_STAT, q);
		chk("host stat", 32'h0, q);
	endtask
	task automatic t_ends();
		ee_write(7'h00, 8'h5a);
		ee_write(7'h7f, 8'ha5);
		chk("host write active", 32'h1, {31'h0, wr_act});
		ee_check(7'h00, 8'h5a);
		ee_check(7'h7f, 8'ha5);
	endtask
	task automatic t_irq();
		logic [31:0] q;
		wr(eac_pkg::H_ISTAT, 32'h3);
		wr(eac_pkg::H_IMASK, 32'h1);
		chk("irq idle", 32'h0, {31'h0, irq});
		ee_write(7'h03, 8'h3c);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(eac_pkg::H_IMASK, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(eac_pkg::H_ISTAT, 32'h1);
		rd(eac_pkg::H_ISTAT, q);
		chk("done cleared", 32'h0, {31'h0, q[eac_pkg::EV_DONE]});
	endtask
	task automatic t_rst_sleep();
		logic [31:0] q;
		wr(eac_pkg::H_ADDR, 32'h9);
		wr(eac_pkg::H_WDATA, 32'hc3);
		wr(eac_pkg::H_CMD, 32'h3);
		// the host starts the write five cycles after the command
		repeat (7) @(posedge core_clk);
		wr(eac_pkg::H_CTRL, 32'h4);
		idle();
		ee_check(7'h09, 8'hc3);
		wr(eac_pkg::H_CTRL, 32'h2);
		ee_write(7'h0a, 8'h77);
		rd(eac_pkg::H_STAT, q);
		chk("osc held", 32'h1, {31'h0, q[2]});
		wr(eac_pkg::H_CTRL, 32'h0);
		ee_check(7'h0a, 8'h77);
		rd(8'h20, q);
		chk("unmapped err", 32'h1, {31'h0, last_err});
		chk("unmapped data", 32'h0, q);
	endtask
	task automatic t_guard();
		logic [7:0] q;
		io_r(eac_pkg::IO_CTRL, q);
		chk("dev ctrl", 32'h0, {24'h0, q});
		io_w(eac_pkg::IO_CTRL, 8'h02);
		io_r(eac_pkg::IO_CTRL, q);
		chk("unarmed write", 32'h0, {31'h0, q[eac_pkg::CTL_WE]});
		io_w(eac_pkg::IO_CTRL, 8'h04);
		io_r(eac_pkg::IO_CTRL, q);
		chk("arm held", 32'h1, {31'h0, q[eac_pkg::CTL_MWE]});
		io_r(eac_pkg::IO_CTRL, q);
		chk("arm expired", 32'h0, {31'h0, q[eac_pkg::CTL_MWE]});
		io_w(eac_pkg::IO_CTRL, 8'h02);
		io_r(eac_pkg::IO_CTRL, q);
		chk("late write", 32'h0, {31'h0, q[eac_pkg::CTL_WE]});
		io_w(eac_pkg::IO_ADDR, 8'hff);
		io_r(eac_pkg::IO_ADDR, q);
		chk("address", 32'h7f, {24'h0, q});
		io_w(eac_pkg::IO_DATA, 8'h96);
		io_r(eac_pkg::IO_DATA, q);
		chk("data", 32'h96, {24'h0, q});
	endtask
	task automatic t_dev_write();
		logic [7:0] q;
		int         n_act;
		int         n_low;
		int         n_stl;
		int         n_abt;
		@(posedge core_clk);
		i_eac_if_2.gie <= 1'b1;
		io_w(eac_pkg::IO_CTRL, 8'h08);
		@(posedge core_clk);
		chk("ready irq", 32'h1, {31'h0, i_eac_if_2.irq_req});
		i_eac_if_2.gie <= 1'b0;
		@(posedge core_clk);
		chk("irq gated", 32'h0, {31'h0, i_eac_if_2.irq_req});
		i_eac_if_2.gie <= 1'b1;
		io_w(eac_pkg::IO_CTRL, 8'h0c);
		io_w(eac_pkg::IO_CTRL, 8'h0e);
		n_act = 0;
		n_low = 0;
		n_stl = 0;
		repeat (40) begin
			@(posedge core_clk);
			n_act += int'(wr_act2 === 1'b1);
			n_low += int'(i_eac_if_2.irq_req === 1'b0);
			n_stl += int'(i_eac_if_2.stall === 1'b1);
		end
		chk("write length", DIV * TCK, n_act);
		chk("irq low span", DIV * TCK, n_low);
		chk("write stall", 32'h2, n_stl);
		io_w(eac_pkg::IO_CTRL, 8'h0c);
		io_w(eac_pkg::IO_CTRL, 8'h0e);
		repeat (2) @(posedge core_clk);
		io_w(eac_pkg::IO_DATA, 8'h55);
		n_abt = 0;
		repeat (6) begin
			@(posedge core_clk);
			n_abt += int'(wr_abt2 === 1'b1);
		end
		chk("abort pulse", 32'h1, n_abt);
		io_r(eac_pkg::IO_CTRL, q);
		chk("aborted idle", 32'h0, {31'h0, q[eac_pkg::CTL_WE]});
		io_w(eac_pkg::IO_CTRL, 8'h01);
		io_r(eac_pkg::IO_DATA, q);
		chk("array after abort", 32'h96, {24'h0, q});
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		i_eac_if_2.io_addr = 6'h0;
		i_eac_if_2.io_wr = 1'b0;
		i_eac_if_2.io_rd = 1'b0;
		i_eac_if_2.io_wdata = 8'h0;
		i_eac_if_2.gie = 1'b0;
		i_eac_if_2.sleep_pd = 1'b0;
		i_eac_if_2.cpu_rst = 1'b0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_ends();
		t_irq();
		t_rst_sleep();
		t_guard();
		t_dev_write();
		summarize();
	end
endmodule
`default_nettype wire
